// ===== pkg/fsr_pkg.sv
package fsr_pkg;

   // Clock period of the system clock in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS = 4;

   // Self-timed durations in nanoseconds; the cycle counts derive from them.
   localparam int unsigned SUSPEND_LATENCY_NS = 20000;
   localparam int unsigned PROGRAM_TIME_NS    = 400000;
   localparam int unsigned ERASE_TIME_NS      = 2000000;
   localparam int unsigned NV_WRITE_TIME_NS   = 100000;

   // Cycle counts, rounded up to whole cycles.
   localparam int unsigned SUS_CYC   = (SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROG_CYC  = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned NV_CYC    = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Width of the operation timers.
   localparam int unsigned TMR_W = 24;

   // Command opcodes.
   localparam logic [7:0] OP_SUSPEND   = 8'h75;
   localparam logic [7:0] OP_RESUME    = 8'h7A;
   localparam logic [7:0] OP_TERMINATE = 8'hF0;
   localparam logic [7:0] OP_RST_EN    = 8'h66;
   localparam logic [7:0] OP_RST_DEV   = 8'h99;
   localparam logic [7:0] OP_PD_EXIT   = 8'hAB;
   localparam logic [7:0] OP_PD_ENTER  = 8'hB9;
   localparam logic [7:0] OP_PROGRAM   = 8'h02;
   localparam logic [7:0] OP_ERASE     = 8'h20;
   localparam logic [7:0] OP_SR_WRITE  = 8'h01;
   localparam logic [7:0] OP_OTP_PROG  = 8'h9B;

   // Status field positions.
   localparam int unsigned SR2_ANY_SUSPEND_FLAG_BIT = 7;
   localparam int unsigned SR2_LOCK_LSB = 3;
   localparam int unsigned SR5_ES_BIT   = 3;
   localparam int unsigned SR5_PS_BIT   = 2;

   // Reset values.
   localparam logic [7:0] SR_RESET  = 8'h00;
   localparam logic [1:0] IO_SINGLE = 2'h0;

   // One-time-programmable register geometry.
   localparam int unsigned OTP_ADDR_W   = 9;
   localparam int unsigned OTP_LOCKS    = 3;
   localparam logic [6:0]  OTP_TOP_BYTE = 7'h7F;
   localparam logic [1:0]  OTP_FACTORY  = 2'h0;

   // Serial framing.
   localparam int unsigned BITCNT_W     = 12;
   localparam int unsigned ADDR_BYTES   = 3;
   localparam int unsigned ID_FIRST_BIT = 32;
   localparam int unsigned ID_LAST_BIT  = 40;

   // Chip-select reset pattern length; expected bit alternates 0,1,0,1.
   localparam logic [2:0] JEDEC_PULSES = 3'h4;

   // Identifier returned on power-down exit; the value is arbitrary.
   localparam logic [7:0] DEVICE_ID_DEF = 8'hA5;

   // Kind of self-timed operation.
   typedef enum logic [1:0] {
      FSR_OP_NONE,
      FSR_OP_PROG,
      FSR_OP_ERASE,
      FSR_OP_NV
   } fsr_op_t;

   // Engine state.
   typedef enum logic [1:0] {
      FSR_ST_IDLE,
      FSR_ST_RUN,
      FSR_ST_ANY_SUSPEND_FLAG
   } fsr_state_t;

endpackage

// ===== rtl/fsr_pin_sync.sv
module fsr_pin_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst,
   // Asynchronous pins in.
   input  wire logic [W-1:0] d,
   // Synchronised level and its edges.
   output logic      [W-1:0] q,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] meta_q;  // First stage, read only by the second stage.
   logic [W-1:0] sync_q;  // Second stage, the usable level.
   logic [W-1:0] prev_q;  // Delayed copy for edge detection.

   // Three flops: two for metastability, one so edges look at clean levels only.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
         prev_q <= RST_VAL;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign q    = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;

endmodule

// ===== rtl/fsr_flash_ctrl.sv
module fsr_flash_ctrl #(
   parameter int unsigned  SUS_CYCLES   = fsr_pkg::SUS_CYC,
   parameter int unsigned  PROG_CYCLES  = fsr_pkg::PROG_CYC,
   parameter int unsigned  ERASE_CYCLES = fsr_pkg::ERASE_CYC,
   parameter int unsigned  NV_CYCLES    = fsr_pkg::NV_CYC,
   parameter logic [7:0]   DEVICE_ID    = fsr_pkg::DEVICE_ID_DEF
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst,
   // Serial pins from the host.
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   input  wire logic       reset_pin_n,
   // Serial output pin.
   output logic            so,
   output logic            so_oe,
   // Mode inputs from the surrounding device logic.
   input  wire logic       ultra_deep_sleep,
   input  wire logic       buf_updating,
   input  wire logic [1:0] io_mode_req,
   input  wire logic       io_mode_load,
   // Status outputs.
   output logic            busy,
   output logic            any_suspend_flag,
   output logic            erase_suspended_flag,
   output logic            program_suspended_flag,
   output logic [2:0]      otp_lock_flags,
   output logic [7:0]      status2,
   output logic [7:0]      status5,
   output logic            deep_sleep,
   output logic [1:0]      io_mode,
   output logic            vol_restore,
   output logic            buf_undefined
);
   import fsr_pkg::*;

   // Parameters that the timers cannot hold are refused.
   if (SUS_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES < 1 || NV_CYCLES < 1 ||
       SUS_CYCLES >= (1 << TMR_W) || PROG_CYCLES >= (1 << TMR_W) ||
       ERASE_CYCLES >= (1 << TMR_W) || NV_CYCLES >= (1 << TMR_W)) begin : g_chk
      $error("fsr_flash_ctrl: cycle parameter out of range");
   end

   localparam logic [TMR_W-1:0] SUS_LD   = TMR_W'(SUS_CYCLES - 1);
   localparam logic [TMR_W-1:0] PROG_LD  = TMR_W'(PROG_CYCLES - 1);
   localparam logic [TMR_W-1:0] ERASE_LD = TMR_W'(ERASE_CYCLES - 1);
   localparam logic [TMR_W-1:0] NV_LD    = TMR_W'(NV_CYCLES - 1);

   // Synchronised pins: bit 3 sck, 2 cs_n, 1 si, 0 reset pin.
   logic [3:0] pin_q;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;

   fsr_pin_sync #(.W(4), .RST_VAL(4'h5)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .d    ({sck, cs_n, si, reset_pin_n}),
      .q    (pin_q),
      .rise (pin_rise),
      .fall (pin_fall)
   );

   wire sck_rise = pin_rise[3];
   wire sck_edge = pin_rise[3] | pin_fall[3];
   wire sck_fall = pin_fall[3];
   wire cs_low   = ~pin_q[2];
   wire cs_rise  = pin_rise[2];
   wire cs_fall  = pin_fall[2];
   wire si_q     = pin_q[1];
   wire pin_low  = ~pin_q[0];

   // Serial framing state.
   logic [BITCNT_W-1:0]   bit_cnt_q;   // Rising clock edges seen in this selection.
   logic [7:0]            shift_q;     // Incoming byte.
   logic [7:0]            opcode_q;    // First byte of the frame.
   logic [OTP_ADDR_W-1:0] addr_q;      // Low address bits of the frame.
   logic [OTP_LOCKS-1:0]  lock_pend_q; // User OTP top bytes written in this frame.
   logic [7:0]            id_sr_q;     // Identifier shifter.
   logic                  rst_en_q;    // Reset-enable armed.
   logic [2:0]            jseq_q;      // Chip-select reset pulses matched.

   wire [7:0]          new_byte = {shift_q[6:0], si_q};
   wire                byte_done = sck_rise & cs_low & (bit_cnt_q[2:0] == 3'h7);
   wire [BITCNT_W-4:0] byte_num  = bit_cnt_q[BITCNT_W-1:3];
   wire                bit_sat   = &bit_cnt_q;

   // OTP byte address of the data byte being finished; bytes stream upward.
   wire [OTP_ADDR_W-1:0] otp_a = addr_q + OTP_ADDR_W'(byte_num - ADDR_BYTES - 1);
   wire otp_top = (opcode_q == OP_OTP_PROG) && (byte_num > ADDR_BYTES) &&
                  (otp_a[6:0] == OTP_TOP_BYTE) && (otp_a[8:7] != OTP_FACTORY);

   // Whole bytes only; a release mid-byte drops the command.
   wire aligned = (bit_cnt_q[2:0] == 3'h0) && (bit_cnt_q != '0);
   wire exec    = cs_rise & aligned;

   // Command decode, valid in the exec cycle.
   wire c_sus  = exec & (opcode_q == OP_SUSPEND) & ~deep_sleep;
   wire c_res  = exec & (opcode_q == OP_RESUME) & ~deep_sleep;
   wire c_term = exec & (opcode_q == OP_TERMINATE) & ~deep_sleep;
   wire c_prog = exec & (opcode_q == OP_PROGRAM) & ~deep_sleep;
   wire c_ers  = exec & (opcode_q == OP_ERASE) & ~deep_sleep;
   wire c_sr   = exec & (opcode_q == OP_SR_WRITE) & ~deep_sleep;
   wire c_otp  = exec & (opcode_q == OP_OTP_PROG) & ~deep_sleep;
   wire c_pdin = exec & (opcode_q == OP_PD_ENTER);
   wire c_pdex = exec & (opcode_q == OP_PD_EXIT);
   wire c_sw   = exec & (opcode_q == OP_RST_DEV) & rst_en_q;

   // Identifier goes out on the falling edges of clocks 32 to 39.
   wire id_win = cs_low && (opcode_q == OP_PD_EXIT) &&
                 (bit_cnt_q >= BITCNT_W'(ID_FIRST_BIT)) &&
                 (bit_cnt_q < BITCNT_W'(ID_LAST_BIT));
   wire id_ld  = sck_fall && id_win && (bit_cnt_q == BITCNT_W'(ID_FIRST_BIT));

   // Chip-select reset: expected bit alternates starting from zero.
   wire j_hit  = cs_rise & ~sck_edge & (si_q == jseq_q[0]);
   wire jedec  = j_hit & (jseq_q == JEDEC_PULSES - 3'h1);

   // Bit counter, byte shifter and frame capture.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_q <= '0;
         shift_q   <= 8'h00;
         opcode_q  <= 8'h00;
         addr_q    <= '0;
      end else if (cs_fall) begin
         bit_cnt_q <= '0;
      end else if (sck_rise && cs_low) begin
         // Saturate so a very long frame never looks aligned by wrapping.
         bit_cnt_q <= bit_sat ? bit_cnt_q : bit_cnt_q + BITCNT_W'(1);
         shift_q   <= new_byte;
         if (byte_done && byte_num == '0) begin
            opcode_q <= new_byte;
         end
         if (byte_done && byte_num != '0 && byte_num <= ADDR_BYTES) begin
            addr_q <= {addr_q[0], new_byte};
         end
      end
   end

   // Lock marks for OTP top bytes, gathered per frame.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_pend_q <= '0;
      end else if (cs_fall) begin
         lock_pend_q <= '0;
      end else if (byte_done && otp_top) begin
         lock_pend_q[otp_a[8:7] - 2'h1] <= 1'b1;
      end
   end

   // Identifier shift and output enable on the serial output pin.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         id_sr_q <= 8'h00;
         so      <= 1'b0;
         so_oe   <= 1'b0;
      end else if (!cs_low) begin
         so_oe <= 1'b0;
      end else if (sck_fall && id_win) begin
         so      <= id_ld ? DEVICE_ID[7] : id_sr_q[7];
         id_sr_q <= id_ld ? {DEVICE_ID[6:0], 1'b0} : {id_sr_q[6:0], 1'b0};
         so_oe   <= 1'b1;
      end else if (sck_fall) begin
         so_oe <= 1'b0;
      end
   end

   // Reset-enable arming and the chip-select reset pattern.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_en_q <= 1'b0;
         jseq_q   <= 3'h0;
      end else begin
         if (exec) begin
            rst_en_q <= (opcode_q == OP_RST_EN);
         end
         if (sck_edge || jedec) begin
            jseq_q <= 3'h0;
         end else if (cs_rise) begin
            // A mismatch that is itself a zero may open a new pattern.
            jseq_q <= j_hit ? jseq_q + 3'h1 : {2'b00, ~si_q};
         end
      end
   end

   // Operation engine state.
   fsr_state_t            st_q, st_d;
   fsr_op_t               op_q, op_d;
   logic [TMR_W-1:0]      tmr_q, tmr_d;       // Remaining run or suspend time.
   logic [TMR_W-1:0]      psave_q, psave_d;   // Saved program progress.
   logic [TMR_W-1:0]      esave_q, esave_d;   // Saved erase progress.
   logic                  es_d, ps_d;
   logic [OTP_LOCKS-1:0]  nvlock_q, nvlock_d; // Locks to set when the OTP write ends.
   logic [OTP_LOCKS-1:0]  locks_d;
   logic                  rst_pend_q;

   // Protected writes hold off every reset and ignore terminate.
   wire nv_busy   = (st_q != FSR_ST_IDLE) && (op_q == FSR_OP_NV);
   wire rst_req   = c_sw | jedec | pin_low;
   wire do_reset  = (rst_req | rst_pend_q) & ~nv_busy;
   wire tmr_zero  = (tmr_q == '0);

   // Next state of the engine; reset wins, then terminate, suspend, resume, start.
   always_comb begin
      st_d     = st_q;
      op_d     = op_q;
      tmr_d    = tmr_zero ? tmr_q : tmr_q - TMR_W'(1);
      psave_d  = psave_q;
      esave_d  = esave_q;
      es_d     = erase_suspended_flag;
      ps_d     = program_suspended_flag;
      nvlock_d = nvlock_q;
      locks_d  = otp_lock_flags;
      if (do_reset) begin
         st_d = FSR_ST_IDLE;
         op_d = FSR_OP_NONE;
         es_d = 1'b0;
         ps_d = 1'b0;
      end else begin
         case (st_q)
            FSR_ST_IDLE: begin
               if (c_res && ps_d) begin
                  // Inner program resumes before the outer erase.
                  st_d  = FSR_ST_RUN;
                  op_d  = FSR_OP_PROG;
                  tmr_d = psave_q;
               end else if (c_res && es_d) begin
                  st_d  = FSR_ST_RUN;
                  op_d  = FSR_OP_ERASE;
                  tmr_d = esave_q;
               end else if (c_prog && !ps_d) begin
                  st_d  = FSR_ST_RUN;
                  op_d  = FSR_OP_PROG;
                  tmr_d = PROG_LD;
               end else if (c_ers && !es_d && !ps_d) begin
                  st_d  = FSR_ST_RUN;
                  op_d  = FSR_OP_ERASE;
                  tmr_d = ERASE_LD;
               end else if (c_sr || c_otp) begin
                  st_d     = FSR_ST_RUN;
                  op_d     = FSR_OP_NV;
                  tmr_d    = NV_LD;
                  nvlock_d = c_otp ? lock_pend_q : '0;
               end
            end
            FSR_ST_RUN: begin
               if (c_term && op_q != FSR_OP_NV) begin
                  // A terminated resumed operation gives up its suspension too.
                  st_d = FSR_ST_IDLE;
                  op_d = FSR_OP_NONE;
                  if (op_q == FSR_OP_PROG) begin
                     ps_d = 1'b0;
                  end else begin
                     es_d = 1'b0;
                  end
               end else if (c_sus && op_q != FSR_OP_NV) begin
                  // Progress is banked now; the flag waits for the latency.
                  st_d = FSR_ST_ANY_SUSPEND_FLAG;
                  tmr_d = SUS_LD;
                  if (op_q == FSR_OP_PROG) begin
                     psave_d = tmr_q;
                  end else begin
                     esave_d = tmr_q;
                  end
               end else if (tmr_zero) begin
                  st_d = FSR_ST_IDLE;
                  op_d = FSR_OP_NONE;
                  if (op_q == FSR_OP_PROG) begin
                     ps_d = 1'b0;
                  end else if (op_q == FSR_OP_ERASE) begin
                     es_d = 1'b0;
                  end else begin
                     locks_d = otp_lock_flags | nvlock_q;
                  end
               end
            end
            FSR_ST_ANY_SUSPEND_FLAG: begin
               if (c_term) begin
                  // Terminate before the wind-down ends cancels the operation.
                  st_d = FSR_ST_IDLE;
                  op_d = FSR_OP_NONE;
                  ps_d = (op_q == FSR_OP_PROG) ? 1'b0 : ps_d;
                  es_d = (op_q == FSR_OP_ERASE) ? 1'b0 : es_d;
               end else if (tmr_zero) begin
                  st_d = FSR_ST_IDLE;
                  op_d = FSR_OP_NONE;
                  ps_d = (op_q == FSR_OP_PROG) ? 1'b1 : ps_d;
                  es_d = (op_q == FSR_OP_ERASE) ? 1'b1 : es_d;
               end
            end
            default: begin
               st_d = FSR_ST_IDLE;
               op_d = FSR_OP_NONE;
            end
         endcase
      end
   end

   // Engine registers and the flags derived from their next values.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q                   <= FSR_ST_IDLE;
         op_q                   <= FSR_OP_NONE;
         tmr_q                  <= '0;
         psave_q                <= '0;
         esave_q                <= '0;
         nvlock_q               <= '0;
         busy                   <= 1'b0;
         erase_suspended_flag   <= 1'b0;
         program_suspended_flag <= 1'b0;
         any_suspend_flag       <= 1'b0;
         otp_lock_flags         <= '0;
         status2                <= SR_RESET;
         status5                <= SR_RESET;
      end else begin
         st_q                   <= st_d;
         op_q                   <= op_d;
         tmr_q                  <= tmr_d;
         psave_q                <= psave_d;
         esave_q                <= esave_d;
         nvlock_q               <= nvlock_d;
         busy                   <= (st_d != FSR_ST_IDLE);
         erase_suspended_flag   <= es_d;
         program_suspended_flag <= ps_d;
         any_suspend_flag       <= es_d | ps_d;
         otp_lock_flags         <= locks_d;
         status2                <= SR_RESET;
         status2[SR2_ANY_SUSPEND_FLAG_BIT]  <= es_d | ps_d;
         status2[SR2_LOCK_LSB +: OTP_LOCKS] <= locks_d;
         status5                <= SR_RESET;
         status5[SR5_ES_BIT]    <= es_d;
         status5[SR5_PS_BIT]    <= ps_d;
      end
   end

   // Deferred reset, power-down, interface mode and buffer validity.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_pend_q    <= 1'b0;
         deep_sleep    <= 1'b0;
         io_mode       <= IO_SINGLE;
         vol_restore   <= 1'b0;
         buf_undefined <= 1'b0;
      end else begin
         vol_restore <= do_reset;
         if (do_reset) begin
            rst_pend_q    <= 1'b0;
            deep_sleep    <= 1'b0;
            io_mode       <= IO_SINGLE;
            // Contents survive unless power was cut or an update was cut short.
            buf_undefined <= ultra_deep_sleep | buf_updating;
         end else begin
            if (rst_req && nv_busy) begin
               rst_pend_q <= 1'b1;
            end
            if (c_pdex) begin
               deep_sleep <= 1'b0;
            end else if (c_pdin && st_q == FSR_ST_IDLE) begin
               deep_sleep <= 1'b1;
            end
            if (io_mode_load) begin
               io_mode <= io_mode_req;
            end
         end
      end
   end

endmodule

// ===== verif/fsr_host_model.sv
module fsr_host_model (
   // Clock that paces the pins.
   input  wire logic clk,
   // Serial pins toward the device.
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   // Serial output pin and its enable from the device.
   input  wire logic so,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [47:0] rx;     // Serial output seen at each clock rise, last bit lowest.
   logic [47:0] oe_rx;  // Output enable seen at the same instants.
   // Mode 0 idle: clock low, device deselected.
   initial begin
      rx = '0;
      oe_rx = '0;
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // Half of a 160 ns link period, ending just after a clock edge.
   task automatic half();
      repeat (20) @(posedge clk);
      #1;
   endtask
   // Sends the low n bits of v, first bit first.
   task automatic frame(input logic [47:0] v, input int unsigned n);
      half();
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si = v[i];
         half();
         // The device moved its output a half period ago, so it is settled here.
         rx = {rx[46:0], so};
         oe_rx = {oe_rx[46:0], so_oe};
         sck = 1'b1;
         half();
         sck = 1'b0;
      end
      half();
      cs_n = 1'b1;
      // A released line must not keep showing the last bit.
      si = ~si;
      half();
   endtask
   // Four select pulses with si taken from p; glitch adds a clock pulse.
   task automatic jrst(input logic [3:0] p, input logic glitch);
      for (int i = 3; i >= 0; i--) begin
         half();
         cs_n = 1'b0;
         si = p[i];
         half();
         if (glitch && i == 1) begin
            sck = 1'b1;
            half();
            sck = 1'b0;
         end
         cs_n = 1'b1;
         half();
      end
      si = ~si;
   endtask
endmodule

// ===== verif/fsr_flash_ctrl_properties.sv
module fsr_flash_ctrl_properties (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       rst,
   // Watched status outputs.
   input wire logic       busy,
   input wire logic       any_suspend_flag,
   input wire logic       erase_suspended_flag,
   input wire logic       program_suspended_flag,
   input wire logic [2:0] otp_lock_flags,
   input wire logic [7:0] status2,
   input wire logic [7:0] status5,
   input wire logic [1:0] io_mode,
   input wire logic       vol_restore
);
   import fsr_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_any;
      any_suspend_flag == (erase_suspended_flag | program_suspended_flag);
   endproperty
   a_any: assert property (p_any) else $error("summary flag wrong");
   property p_sr2;
      status2 == {any_suspend_flag, 1'b0, otp_lock_flags, 3'h0};
   endproperty
   a_sr2: assert property (p_sr2) else $error("status2 wrong");
   property p_sr5;
      status5 == {4'h0, erase_suspended_flag, program_suspended_flag, 2'h0};
   endproperty
   a_sr5: assert property (p_sr5) else $error("status5 wrong");
   // The flag may only appear as the wind-down ends.
   property p_ps_up;
      $rose(program_suspended_flag) |-> $fell(busy);
   endproperty
   a_ps_up: assert property (p_ps_up) else $error("ps rose early");
   property p_es_up;
      $rose(erase_suspended_flag) |-> $fell(busy);
   endproperty
   a_es_up: assert property (p_es_up) else $error("es rose early");
   // A flag clears only at completion, at terminate, or by an internal reset.
   property p_ps_dn;
      $fell(program_suspended_flag) |-> $fell(busy) || vol_restore;
   endproperty
   a_ps_dn: assert property (p_ps_dn) else $error("ps fell early");
   property p_es_dn;
      $fell(erase_suspended_flag) |-> $fell(busy) || vol_restore;
   endproperty
   a_es_dn: assert property (p_es_dn) else $error("es fell early");
   property p_rst;
      vol_restore |-> io_mode == IO_SINGLE && !busy && !any_suspend_flag;
   endproperty
   a_rst: assert property (p_rst) else $error("reset incomplete");
   c_ps: cover property ($rose(program_suspended_flag));
   c_nest: cover property (status5 == 8'h0C);
   c_rst: cover property (vol_restore);
   c_lock: cover property ($rose(otp_lock_flags[0]));
endmodule
bind fsr_flash_ctrl fsr_flash_ctrl_properties fsr_flash_ctrl_properties_i (.clk, .rst,
   .busy, .any_suspend_flag, .erase_suspended_flag, .program_suspended_flag,
   .otp_lock_flags, .status2, .status5, .io_mode, .vol_restore);

// ===== verif/fsr_flash_ctrl_tb.sv
module fsr_flash_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fsr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, sck, cs_n, si, so, so_oe, reset_pin_n = 1'b1;
   logic ultra_deep_sleep = 1'b0, buf_updating = 1'b0, io_mode_load = 1'b0;
   logic [1:0] io_mode_req = 2'h0, io_mode;
   logic busy, any_suspend_flag, erase_suspended_flag, program_suspended_flag;
   logic deep_sleep, vol_restore, buf_undefined;
   logic [2:0] otp_lock_flags;
   logic [7:0] status2, status5;
   int err_count = 0;
   int n_compared = 0;
   always #2 clk = ~clk;
   fsr_host_model fsr_host_model_i (.clk, .sck, .cs_n, .si, .so, .so_oe);
   // Long self-timed counts are shortened to keep the run brief.
   fsr_flash_ctrl #(.SUS_CYCLES(60), .PROG_CYCLES(2000), .ERASE_CYCLES(3000),
      .NV_CYCLES(2000)) fsr_flash_ctrl_i (.clk, .rst, .sck, .cs_n, .si, .reset_pin_n,
      .so, .so_oe, .ultra_deep_sleep, .buf_updating, .io_mode_req, .io_mode_load, .busy,
      .any_suspend_flag, .erase_suspended_flag, .program_suspended_flag,
      .otp_lock_flags, .status2, .status5, .deep_sleep, .io_mode, .vol_restore,
      .buf_undefined);
   task automatic end_sim();
      if (err_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait for the engine to go idle; running out ends the run.
   task automatic wait_idle();
      int i;
      for (i = 0; i < 20000 && busy !== 1'b0; i++) tick(1);
      if (i == 20000) begin
         err_count++;
         end_sim();
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      fsr_host_model_i.frame(c, 8);
      tick(8);
   endtask
   task automatic set_mode(input logic [1:0] m);
      io_mode_req = m;
      io_mode_load = 1'b1;
      tick(1);
      io_mode_load = 1'b0;
   endtask
   initial begin
      tick(12);
      rst = 1'b0;
      chk(8'({busy, any_suspend_flag, io_mode, deep_sleep}), 8'h00);
      fsr_host_model_i.frame({OP_PROGRAM, 24'h0, 8'h55}, 40);
      cmd(OP_SUSPEND);
      chk(8'({busy, program_suspended_flag}), 8'h02);
      wait_idle();
      chk(status5, 8'h04);
      chk(status2, 8'h80);
      cmd(OP_TERMINATE);
      chk(8'({busy, program_suspended_flag}), 8'h01);
      cmd(OP_RESUME);
      chk(8'({busy, program_suspended_flag}), 8'h03);
      wait_idle();
      chk(status5, 8'h00);
      fsr_host_model_i.frame({OP_ERASE, 24'h0}, 32);
      cmd(OP_SUSPEND);
      wait_idle();
      chk(status5, 8'h08);
      fsr_host_model_i.frame({OP_PROGRAM, 24'h10, 8'hAA}, 40);
      cmd(OP_SUSPEND);
      wait_idle();
      chk(status5, 8'h0C);
      fsr_host_model_i.frame({OP_ERASE, 24'h0}, 32);
      chk(8'(busy), 8'h00);
      chk(status5, 8'h0C);
      cmd(OP_RESUME);
      wait_idle();
      chk(status5, 8'h08);
      cmd(OP_RESUME);
      wait_idle();
      chk(status2, 8'h00);
      fsr_host_model_i.frame({OP_PROGRAM, 24'h0, 8'h11}, 40);
      cmd(OP_TERMINATE);
      chk(8'(busy), 8'h00);
      fsr_host_model_i.frame({OP_OTP_PROG, 15'h0, 9'h0FF, 8'h00}, 40);
      cmd(OP_TERMINATE);
      chk(8'(busy), 8'h01);
      set_mode(2'h2);
      fsr_host_model_i.jrst(4'h5, 1'b0);
      chk(8'({busy, io_mode}), 8'h06);
      // An update in flight when the deferred reset lands spoils the buffer.
      buf_updating = 1'b1;
      wait_idle();
      tick(4);
      chk(8'({otp_lock_flags, io_mode}), 8'h04);
      chk(8'(buf_undefined), 8'h01);
      buf_updating = 1'b0;
      fsr_host_model_i.frame({OP_PROGRAM, 24'h0, 8'h33}, 40);
      fsr_host_model_i.frame({OP_SUSPEND, 1'b0}, 9);
      tick(80);
      chk(8'({busy, any_suspend_flag}), 8'h02);
      set_mode(2'h1);
      fsr_host_model_i.jrst(4'h5, 1'b1);
      chk(8'(io_mode), 8'h01);
      cmd(OP_RST_EN);
      cmd(OP_RST_DEV);
      chk(8'({busy, io_mode}), 8'h00);
      chk(8'(buf_undefined), 8'h00);
      cmd(OP_PD_ENTER);
      fsr_host_model_i.frame({OP_PD_EXIT, 33'h0}, 41);
      tick(8);
      chk(8'(deep_sleep), 8'h01);
      chk(fsr_host_model_i.rx[8:1], DEVICE_ID_DEF);
      chk(fsr_host_model_i.oe_rx[9:2], 8'h7F);
      chk(8'(fsr_host_model_i.oe_rx[1:0]), 8'h02);
      cmd(OP_PD_EXIT);
      chk(8'(deep_sleep), 8'h00);
      fsr_host_model_i.frame({OP_ERASE, 24'h0}, 32);
      ultra_deep_sleep = 1'b1;
      reset_pin_n = 1'b0;
      tick(10);
      reset_pin_n = 1'b1;
      tick(10);
      chk(8'({busy, buf_undefined}), 8'h01);
      end_sim();
   end
endmodule
